// ===== logic/lpc_host_if_control_regs.sv
// Our own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module lpc_host_if_control_regs
  import lpc_hif_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic [31:0] haddr,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic lpc_clk,
  input wire logic lpc_frame_n,
  input wire logic serial_irq,
  input wire logic lpc_reset_n,
  input wire logic lpc_xfer_active,
  input wire logic ch1_ibf,
  input wire logic ch2_ibf,
  input wire logic ch3_ibf,
  input wire logic two_way_buffer_full,
  input wire logic mode_irq_req,
  input wire logic ch3_host_hit,
  output logic ch1_rx_irq,
  output logic ch2_rx_irq,
  output logic ch3_rx_irq,
  output logic error_irq,
  output logic slave_irq,
  output logic shared_addr_channel_select,
  output logic [2:0] ch1_offset,
  output logic [2:0] ch2_offset,
  output logic [3:0] sync_wait_code,
  output logic ch3_keyboard_match,
  output logic ch3_enable,
  output logic two_way_buffer_irq_enable
);

  reg_access_if bus ();

  // set beats clear on every sticky bit
  function automatic logic [EVT_W-1:0] sticky(
    input logic [EVT_W-1:0] q,
    input logic [EVT_W-1:0] set,
    input logic [EVT_W-1:0] clr
  );
    sticky = set | (q & ~clr);
  endfunction

  ahb_reg_port u_port (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .htrans(htrans),
    .haddr(haddr),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .bus(bus)
  );

  // pins: clock, reset, serial irq, frame
  logic [3:0] pin_lvl;
  logic [3:0] pin_rise;
  logic [3:0] pin_fall;

  pin_sync #(
    .W(4),
    .RST_VAL(4'hF)
  ) u_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .pin({lpc_clk, lpc_reset_n, serial_irq, lpc_frame_n}),
    .lvl(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  wire frame_lvl = pin_lvl[0];
  wire sirq_lvl = pin_lvl[1];
  wire reset_lvl = pin_lvl[2];
  wire reset_fall = pin_fall[2];
  wire link_edge = pin_rise[3];
  wire unused_edges = ^{pin_rise[2:0], pin_fall[3], pin_fall[1:0], pin_lvl[3]};

  // register state
  logic [3:0] irq_en_q;
  logic reset_detect_q;
  logic abort_q;
  logic [7:0] ch3_ctrl_q;
  logic ch3_en_q;
  logic two_way_ie_q;
  logic [EVT_W-1:0] evt_stat_q;
  logic [EVT_W-1:0] evt_mask_q;
  logic frame_at_edge_q;
  logic [2:0] irq_prev_q;

  // write decode
  wire wr_irq = bus.wr_en && (bus.addr == IRQ_CTRL_OFS);
  wire wr_ch3 = bus.wr_en && (bus.addr == CH3_CTRL_OFS);
  wire wr_cfg = bus.wr_en && (bus.addr == CH3_CFG_OFS);
  wire wr_stat = bus.wr_en && (bus.addr == EVT_STAT_OFS);
  wire wr_mask = bus.wr_en && (bus.addr == EVT_MASK_OFS);

  // frame is looked at on link clock rising edges only
  wire abort_set = link_edge & lpc_xfer_active & frame_at_edge_q & ~frame_lvl;
  wire rst_set = reset_fall;

  // zero written to a flag clears it, one leaves it
  wire rst_clr = wr_irq & ~bus.wdata[RST_DET_BIT];
  wire abort_clr = (wr_irq & ~bus.wdata[ABORT_BIT]) | rst_set;

  // flags as one-bit sticky cells
  logic [EVT_W-1:0] flag_d;
  assign flag_d = sticky({3'h0, reset_detect_q, abort_q},
                         {3'h0, rst_set, abort_set},
                         {3'h0, rst_clr, abort_clr});

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reset_detect_q <= 1'b0;
      abort_q <= 1'b0;
      frame_at_edge_q <= 1'b1;
    end else begin
      reset_detect_q <= flag_d[1];
      abort_q <= flag_d[0];
      if (link_edge) frame_at_edge_q <= frame_lvl;
    end
  end

  // enables and control fields
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_en_q <= IRQ_EN_RST;
      ch3_ctrl_q <= CH3_CTRL_RST;
      ch3_en_q <= 1'b0;
      two_way_ie_q <= 1'b0;
    end else begin
      if (wr_irq) irq_en_q <= bus.wdata[3:0];
      if (wr_ch3) ch3_ctrl_q <= bus.wdata[7:0];
      if (wr_cfg) ch3_en_q <= bus.wdata[CH3_EN_BIT];
      if (wr_cfg) two_way_ie_q <= bus.wdata[TWO_WAY_IE_BIT];
    end
  end

  // request lines: flag and enable, nothing held
  assign ch1_rx_irq = irq_en_q[EN_CH1_BIT] & ch1_ibf;
  assign ch2_rx_irq = irq_en_q[EN_CH2_BIT] & ch2_ibf;
  wire ch3_src = ch3_ibf | mode_irq_req | (two_way_ie_q & two_way_buffer_full);
  assign ch3_rx_irq = irq_en_q[EN_CH3_BIT] & ch3_src;
  assign error_irq = irq_en_q[EN_ERR_BIT] & (reset_detect_q | abort_q);

  // channel 3 options decoded for the host side
  assign shared_addr_channel_select = ch3_ctrl_q[ADDR_SEL_BIT];
  assign ch1_offset = ch3_ctrl_q[CH1_OFS_BIT] ? OFFSET_ONE : OFFSET_FOUR;
  assign ch2_offset = ch3_ctrl_q[CH2_OFS_BIT] ? OFFSET_ONE : OFFSET_FOUR;
  assign sync_wait_code = ch3_ctrl_q[WAIT_LEN_BIT] ? LONG_WAIT_CODE : SHORT_WAIT_CODE;
  // keyboard bit only counts while channel 3 enable is off
  wire keyboard_allow = ch3_en_q | ch3_ctrl_q[KEYBOARD_EN_BIT];
  assign ch3_keyboard_match = ch3_host_hit & keyboard_allow;
  assign ch3_enable = ch3_en_q;
  assign two_way_buffer_irq_enable = two_way_ie_q;

  // events for the system interrupt: rising request lines, link reset and abort
  wire [2:0] irq_now = {ch3_rx_irq, ch2_rx_irq, ch1_rx_irq};
  wire [2:0] irq_rise = irq_now & ~irq_prev_q;
  wire [EVT_W-1:0] evt_set = {abort_set, rst_set, irq_rise};
  wire [EVT_W-1:0] evt_clr = wr_stat ? bus.wdata[EVT_W-1:0] : EVT_RST;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_prev_q <= 3'h0;
      evt_stat_q <= EVT_RST;
      evt_mask_q <= EVT_RST;
    end else begin
      irq_prev_q <= irq_now;
      evt_stat_q <= sticky(evt_stat_q, evt_set, evt_clr);
      if (wr_mask) evt_mask_q <= bus.wdata[EVT_W-1:0];
    end
  end

  assign slave_irq = |(evt_stat_q & evt_mask_q);

  // read views; undefined bits read zero
  logic [7:0] irq_view;
  logic [7:0] mon_view;
  always_comb begin
    irq_view = 8'h00;
    irq_view[3:0] = irq_en_q;
    irq_view[ABORT_BIT] = abort_q;
    irq_view[RST_DET_BIT] = reset_detect_q;
    mon_view = 8'h00;
    mon_view[MON_FRAME_BIT] = frame_lvl;
    mon_view[MON_SIRQ_BIT] = sirq_lvl;
    mon_view[MON_RESET_BIT] = reset_lvl;
  end

  // read mux; unmapped reads zero, pin monitor ignores writes
  always_comb begin
    if (bus.addr == IRQ_CTRL_OFS) begin
      bus.rdata = {24'h000000, irq_view};
    end else if (bus.addr == PIN_MON_OFS) begin
      bus.rdata = {24'h000000, mon_view};
    end else if (bus.addr == CH3_CTRL_OFS) begin
      bus.rdata = {24'h000000, ch3_ctrl_q};
    end else if (bus.addr == CH3_CFG_OFS) begin
      bus.rdata = {30'h00000000, two_way_ie_q, ch3_en_q};
    end else if (bus.addr == EVT_STAT_OFS) begin
      bus.rdata = {27'h0000000, evt_stat_q};
    end else if (bus.addr == EVT_MASK_OFS) begin
      bus.rdata = {27'h0000000, evt_mask_q};
    end else begin
      bus.rdata = 32'h00000000;
    end
  end

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_ch3_block;
    !irq_en_q[EN_CH3_BIT] |-> !ch3_rx_irq;
  endproperty
  a_ch3_block: assert property (p_ch3_block) else $error("ch3 request not blocked");

  property p_two_way_gate;
    irq_en_q[EN_CH3_BIT] && two_way_buffer_full && !ch3_ibf && !mode_irq_req
      |-> (ch3_rx_irq == two_way_ie_q);
  endproperty
  a_two_way_gate: assert property (p_two_way_gate) else $error("two-way gating wrong");

  property p_ch2_enable;
    wr_irq && bus.wdata[EN_CH2_BIT] |=> (ch2_rx_irq == ch2_ibf);
  endproperty
  a_ch2_enable: assert property (p_ch2_enable) else $error("ch2 enable ignored");

  property p_ch1_disable;
    wr_irq && !bus.wdata[EN_CH1_BIT] |=> !ch1_rx_irq;
  endproperty
  a_ch1_disable: assert property (p_ch1_disable) else $error("ch1 disable ignored");

  property p_err_cause;
    error_irq |-> irq_en_q[EN_ERR_BIT] && (reset_detect_q || abort_q);
  endproperty
  a_err_cause: assert property (p_err_cause) else $error("error irq without cause");

  property p_flag_keep;
    reset_detect_q && wr_irq && bus.wdata[RST_DET_BIT] |=> reset_detect_q;
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("writing one cleared flag");

  property p_mon_frame;
    bus.addr == PIN_MON_OFS |-> bus.rdata[MON_FRAME_BIT] == frame_lvl && bus.rdata[6] == 1'b0;
  endproperty
  a_mon_frame: assert property (p_mon_frame) else $error("pin monitor view wrong");

  property p_sel_write;
    wr_ch3 |=> shared_addr_channel_select == $past(bus.wdata[ADDR_SEL_BIT]);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("select not stored");

  property p_ch2_offset;
    wr_ch3 && !bus.wdata[CH2_OFS_BIT] |=> ch2_offset == OFFSET_FOUR;
  endproperty
  a_ch2_offset: assert property (p_ch2_offset) else $error("ch2 offset wrong");

  property p_ch1_offset;
    wr_ch3 && bus.wdata[CH1_OFS_BIT] |=> ch1_offset == OFFSET_ONE;
  endproperty
  a_ch1_offset: assert property (p_ch1_offset) else $error("ch1 offset wrong");

  property p_wait_code;
    wr_ch3 && bus.wdata[WAIT_LEN_BIT] |=> sync_wait_code == LONG_WAIT_CODE;
  endproperty
  a_wait_code: assert property (p_wait_code) else $error("wait code wrong");

  property p_keyboard_block;
    !ch3_en_q && !ch3_ctrl_q[KEYBOARD_EN_BIT] |-> !ch3_keyboard_match;
  endproperty
  a_keyboard_block: assert property (p_keyboard_block) else $error("ch3 matched while off");

  // two sync stages, one edge to find the fall, flag visible at the next sample
  property p_reset_flag;
    $fell(lpc_reset_n) |-> ##3 reset_detect_q;
  endproperty
  a_reset_flag: assert property (p_reset_flag) else $error("reset flag not set");

  property p_abort_flag;
    abort_set |=> abort_q;
  endproperty
  a_abort_flag: assert property (p_abort_flag) else $error("abort flag not set");

  property p_slave_irq;
    (evt_set & evt_mask_q) != EVT_RST && !wr_mask |=> slave_irq;
  endproperty
  a_slave_irq: assert property (p_slave_irq) else $error("system irq missing");

  property p_cov_err;
    rst_set ##1 error_irq;
  endproperty
  c_cov_err: cover property (p_cov_err);

  property p_cov_abort;
    abort_set ##1 abort_q;
  endproperty
  c_cov_abort: cover property (p_cov_abort);

  property p_cov_mon;
    bus.rd_en && bus.addr == PIN_MON_OFS;
  endproperty
  c_cov_mon: cover property (p_cov_mon);

endmodule
`default_nettype wire

// ===== logic/lpc_hif_pkg.sv
package lpc_hif_pkg;
  // register byte offsets
  localparam logic [7:0] IRQ_CTRL_OFS = 8'h00;
  localparam logic [7:0] PIN_MON_OFS = 8'h04;
  localparam logic [7:0] CH3_CTRL_OFS = 8'h08;
  localparam logic [7:0] CH3_CFG_OFS = 8'h0C;
  localparam logic [7:0] EVT_STAT_OFS = 8'h10;
  localparam logic [7:0] EVT_MASK_OFS = 8'h14;
  localparam int ADDR_W = 8;

  // interrupt control fields
  localparam int EN_ERR_BIT = 0;
  localparam int EN_CH1_BIT = 1;
  localparam int EN_CH2_BIT = 2;
  localparam int EN_CH3_BIT = 3;
  localparam int ABORT_BIT = 4;
  localparam int RST_DET_BIT = 6;
  localparam logic [3:0] IRQ_EN_RST = 4'h0;

  // pin monitor fields
  localparam int MON_RESET_BIT = 4;
  localparam int MON_SIRQ_BIT = 5;
  localparam int MON_FRAME_BIT = 7;

  // channel 3 control fields
  localparam int WAIT_LEN_BIT = 3;
  localparam int KEYBOARD_EN_BIT = 2;
  localparam int CH1_OFS_BIT = 4;
  localparam int CH2_OFS_BIT = 5;
  localparam int ADDR_SEL_BIT = 7;
  localparam logic [7:0] CH3_CTRL_RST = 8'h00;

  // own config fields
  localparam int CH3_EN_BIT = 0;
  localparam int TWO_WAY_IE_BIT = 1;

  // event status layout
  localparam int EVT_W = 5;
  localparam logic [EVT_W-1:0] EVT_RST = 5'h00;

  // codes and offsets
  localparam logic [3:0] SHORT_WAIT_CODE = 4'h5;
  localparam logic [3:0] LONG_WAIT_CODE = 4'h6;
  localparam logic [2:0] OFFSET_FOUR = 3'h4;
  localparam logic [2:0] OFFSET_ONE = 3'h1;

  // bus port states, gray along idle-read-done
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_RD_WAIT = 2'b01,
    BUS_RD_DONE = 2'b11,
    BUS_WRITE = 2'b10
  } bus_state_e;
endpackage

// ===== logic/reg_access_if.sv
`timescale 1ns/10ps
`default_nettype none
interface reg_access_if;
  logic wr_en;
  logic rd_en;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport port (output wr_en, output rd_en, output addr, output wdata, input rdata);
  modport regs (input wr_en, input rd_en, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ===== logic/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] lvl,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // s1 feeds only s2
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // edges from settled stages
  assign lvl = s2_q;
  assign rise = s2_q & ~s3_q;
  assign fall = ~s2_q & s3_q;
endmodule
`default_nettype wire

// ===== logic/ahb_reg_port.sv
`timescale 1ns/10ps
`default_nettype none
module ahb_reg_port
  import lpc_hif_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic [31:0] haddr,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  reg_access_if.port bus
);
  bus_state_e state_q, state_d;
  logic [ADDR_W-1:0] addr_q;
  logic [31:0] rdata_q;
  wire take = hsel & hready & htrans[1];

  // only word transfers are used; size is not checked
  wire unused_size = ^hsize;

  // next state
  always_comb begin
    state_d = BUS_IDLE;
    case (state_q)
      BUS_RD_WAIT: state_d = BUS_RD_DONE;
      default: begin
        if (take) begin
          state_d = hwrite ? BUS_WRITE : BUS_RD_WAIT;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= BUS_IDLE;
      addr_q <= '0;
      rdata_q <= '0;
    end else begin
      state_q <= state_d;
      if (take) addr_q <= haddr[ADDR_W-1:0];
      if (state_q == BUS_RD_WAIT) rdata_q <= bus.rdata;
    end
  end

  // one wait state on reads keeps hrdata registered
  assign hreadyout = (state_q != BUS_RD_WAIT);
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign bus.wr_en = (state_q == BUS_WRITE);
  assign bus.rd_en = (state_q == BUS_RD_WAIT);
  assign bus.addr = addr_q;
  assign bus.wdata = hwdata;

  property p_read_wait;
    @(posedge hclk) disable iff (!hresetn)
    take && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");
endmodule
`default_nettype wire

// ===== test/lpc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// behavioural link host: clock runs only inside frames, frame line pulled up between them
module lpc_host_model (
  input wire logic hclk,
  output logic lpc_clk,
  output logic lpc_frame_n,
  output logic serial_irq,
  output logic lpc_reset_n,
  output logic lpc_xfer_active
);
  // idle pin levels: frame, serial irq and reset released high, clock and transfer window low
  initial begin
    lpc_clk = 1'b0;
    lpc_frame_n = 1'b1;
    serial_irq = 1'b1;
    lpc_reset_n = 1'b1;
    lpc_xfer_active = 1'b0;
  end

  // one 400 ns link period, frame set in the low half so it is stable at the rise
  task automatic link_cycle(input logic frame);
    lpc_frame_n = frame;
    #200 lpc_clk = 1'b1;
    #200 lpc_clk = 1'b0;
  endtask

  // start frame, then a transfer window; abort holds frame low four periods
  task automatic xfer(input bit abort);
    #13;
    link_cycle(1'b0);
    // window opens late so the start frame is never taken for an abort
    repeat (4) @(posedge hclk);
    lpc_xfer_active <= 1'b1;
    repeat (3) link_cycle(1'b1);
    if (abort) begin
      repeat (4) link_cycle(1'b0);
    end
    link_cycle(1'b1);
    @(posedge hclk);
    lpc_xfer_active <= 1'b0;
  endtask

  // link reset pulse, long enough for the two-flop sync
  task automatic reset_pulse;
    #7 lpc_reset_n = 1'b0;
    #1000 lpc_reset_n = 1'b1;
    #1000;
  endtask

  task automatic set_sirq(input logic v);
    serial_irq = v;
  endtask
endmodule
`default_nettype wire

// ===== test/lpc_host_if_control_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module lpc_host_if_control_regs_tb
  import lpc_hif_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rdy_s;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, hrd_s;
  logic lpc_clk, lpc_frame_n, serial_irq, lpc_reset_n, lpc_xfer_active;
  logic ch1_ibf, ch2_ibf, ch3_ibf, two_way_buffer_full, mode_irq_req, ch3_host_hit;
  logic ch1_rx_irq, ch2_rx_irq, ch3_rx_irq, error_irq, slave_irq;
  logic shared_addr_channel_select, ch3_keyboard_match, ch3_enable, two_way_buffer_irq_enable;
  logic [2:0] ch1_offset, ch2_offset;
  logic [3:0] sync_wait_code;
  int miscompares = 0;
  int cmp_count = 0;

  lpc_host_if_control_regs lpc_host_if_control_regs_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .haddr(haddr),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .lpc_clk(lpc_clk),
    .lpc_frame_n(lpc_frame_n), .serial_irq(serial_irq), .lpc_reset_n(lpc_reset_n),
    .lpc_xfer_active(lpc_xfer_active), .ch1_ibf(ch1_ibf), .ch2_ibf(ch2_ibf),
    .ch3_ibf(ch3_ibf), .two_way_buffer_full(two_way_buffer_full),
    .mode_irq_req(mode_irq_req), .ch3_host_hit(ch3_host_hit), .ch1_rx_irq(ch1_rx_irq),
    .ch2_rx_irq(ch2_rx_irq), .ch3_rx_irq(ch3_rx_irq), .error_irq(error_irq),
    .slave_irq(slave_irq), .shared_addr_channel_select(shared_addr_channel_select),
    .ch1_offset(ch1_offset), .ch2_offset(ch2_offset), .sync_wait_code(sync_wait_code),
    .ch3_keyboard_match(ch3_keyboard_match), .ch3_enable(ch3_enable),
    .two_way_buffer_irq_enable(two_way_buffer_irq_enable)
  );

  lpc_host_model lpc_host_model_inst (
    .hclk(hclk), .lpc_clk(lpc_clk), .lpc_frame_n(lpc_frame_n), .serial_irq(serial_irq),
    .lpc_reset_n(lpc_reset_n), .lpc_xfer_active(lpc_xfer_active)
  );

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // bus answer taken mid-cycle, so the edge decision never races the slave's update
  always @(negedge hclk) begin
    rdy_s = hreadyout;
    hrd_s = hrdata;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // single word transfer: address phase held until ready, then data phase until ready
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    hsize <= 3'b010;
    do @(posedge hclk); while (rdy_s !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (rdy_s !== 1'b1);
    rd = hrd_s;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string m);
    logic [31:0] x;
    bus(1'b0, a, 32'h00000000, x);
    check(x, e, m);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask

  // request sources change together on one edge, outputs looked at one cycle later
  task automatic drive_src(input logic [2:0] ibf, input logic tw, input logic mode);
    @(posedge hclk);
    {ch3_ibf, ch2_ibf, ch1_ibf} <= ibf;
    two_way_buffer_full <= tw;
    mode_irq_req <= mode;
    tick(1);
  endtask

  task automatic t_reset;
    rd_chk(IRQ_CTRL_OFS, 32'h00000000, "irq control reset");
    rd_chk(CH3_CTRL_OFS, 32'h00000000, "ch3 control reset");
    check(ch1_offset, OFFSET_FOUR, "ch1 offset reset");
    check(ch2_offset, OFFSET_FOUR, "ch2 offset reset");
    check(sync_wait_code, SHORT_WAIT_CODE, "wait code reset");
    check(hresp, 1'b0, "response always okay");
    rd_chk(PIN_MON_OFS, 32'h000000B0, "pins idle high");
    lpc_host_model_inst.set_sirq(1'b0);
    tick(4);
    rd_chk(PIN_MON_OFS, 32'h00000090, "serial irq low");
    wr(PIN_MON_OFS, 32'h000000FF);
    rd_chk(PIN_MON_OFS, 32'h00000090, "monitor ignores writes");
    rd_chk(8'h20, 32'h00000000, "unmapped reads zero");
    lpc_host_model_inst.set_sirq(1'b1);
    $display("test reset done");
  endtask

  task automatic t_enables;
    for (int i = 0; i < 3; i++) begin
      drive_src(3'b001 << i, 1'b0, 1'b0);
      check({ch3_rx_irq, ch2_rx_irq, ch1_rx_irq}, 0, "blocked while disabled");
      wr(IRQ_CTRL_OFS, 32'h00000002 << i);
      tick(1);
      check({ch3_rx_irq, ch2_rx_irq, ch1_rx_irq}, 32'h1 << i, "enabled request");
      drive_src(3'b000, 1'b0, 1'b0);
      check({ch3_rx_irq, ch2_rx_irq, ch1_rx_irq}, 0, "drops with source");
    end
    rd_chk(EVT_STAT_OFS, 32'h00000007, "request rise events");
    drive_src(3'b000, 1'b0, 1'b1);
    check(ch3_rx_irq, 1'b1, "mode request passes");
    drive_src(3'b000, 1'b1, 1'b0);
    check(ch3_rx_irq, 1'b0, "two-way needs its enable");
    wr(CH3_CFG_OFS, 32'h00000002);
    tick(1);
    check(ch3_rx_irq, 1'b1, "two-way enabled");
    check(two_way_buffer_irq_enable, 1'b1, "two-way enable output");
    rd_chk(CH3_CFG_OFS, 32'h00000002, "config readback");
    wr(IRQ_CTRL_OFS, 32'h00000000);
    tick(1);
    check(ch3_rx_irq, 1'b0, "enable clear blocks two-way");
    drive_src(3'b000, 1'b0, 1'b0);
    wr(CH3_CFG_OFS, 32'h00000000);
    $display("test enables done");
  endtask

  task automatic t_ch3ctrl;
    logic [7:0] vals [5] = '{8'h80, 8'h20, 8'h10, 8'h08, 8'h04};
    foreach (vals[i]) begin
      wr(CH3_CTRL_OFS, {24'h000000, vals[i]});
      tick(1);
      rd_chk(CH3_CTRL_OFS, {24'h000000, vals[i]}, "ch3 control readback");
      check(shared_addr_channel_select, vals[i][7], "address select");
      check(ch2_offset, vals[i][5] ? OFFSET_ONE : OFFSET_FOUR, "ch2 offset");
      check(ch1_offset, vals[i][4] ? OFFSET_ONE : OFFSET_FOUR, "ch1 offset");
      check(sync_wait_code, vals[i][3] ? LONG_WAIT_CODE : SHORT_WAIT_CODE, "wait code");
    end
    @(posedge hclk);
    ch3_host_hit <= 1'b1;
    tick(1);
    check(ch3_keyboard_match, 1'b1, "keyboard bit allows match");
    wr(CH3_CTRL_OFS, 32'h00000000);
    tick(1);
    check(ch3_keyboard_match, 1'b0, "no match with both off");
    wr(CH3_CFG_OFS, 32'h00000001);
    tick(1);
    check(ch3_keyboard_match, 1'b1, "ch3 enable matches");
    check(ch3_enable, 1'b1, "ch3 enable output");
    wr(CH3_CFG_OFS, 32'h00000000);
    $display("test ch3 control done");
  endtask

  task automatic t_errors;
    wr(EVT_STAT_OFS, 32'h0000001F);
    wr(EVT_MASK_OFS, 32'h00000018);
    wr(IRQ_CTRL_OFS, 32'h00000001);
    lpc_host_model_inst.reset_pulse();
    tick(2);
    rd_chk(IRQ_CTRL_OFS, 32'h00000041, "reset flag set");
    check(error_irq, 1'b1, "error irq from reset");
    check(slave_irq, 1'b1, "unmasked status raises");
    wr(IRQ_CTRL_OFS, 32'h00000051);
    rd_chk(IRQ_CTRL_OFS, 32'h00000041, "writing one keeps flag");
    wr(IRQ_CTRL_OFS, 32'h00000040);
    tick(1);
    check(error_irq, 1'b0, "error enable clear blocks");
    wr(IRQ_CTRL_OFS, 32'h00000001);
    rd_chk(IRQ_CTRL_OFS, 32'h00000001, "writing zero clears");
    rd_chk(EVT_STAT_OFS, 32'h00000008, "reset event status");
    wr(EVT_STAT_OFS, 32'h00000008);
    tick(1);
    check(slave_irq, 1'b0, "status cleared by one");
    lpc_host_model_inst.xfer(1'b0);
    tick(2);
    rd_chk(IRQ_CTRL_OFS, 32'h00000001, "clean transfer no abort");
    lpc_host_model_inst.xfer(1'b1);
    tick(2);
    rd_chk(IRQ_CTRL_OFS, 32'h00000011, "abort flag set");
    check(error_irq, 1'b1, "error irq from abort");
    check(slave_irq, 1'b1, "abort event raises");
    wr(EVT_MASK_OFS, 32'h00000000);
    tick(1);
    check(slave_irq, 1'b0, "masked status silent");
    wr(IRQ_CTRL_OFS, 32'h00000001);
    tick(1);
    check(error_irq, 1'b0, "abort cleared");
    $display("test errors done");
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // runs well under a millisecond; the watchdog leaves ample room
  initial begin
    #2000000;
    miscompares++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    wrap_up();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h00000000;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h00000000;
    {ch3_ibf, ch2_ibf, ch1_ibf} = 3'b000;
    two_way_buffer_full = 1'b0;
    mode_irq_req = 1'b0;
    ch3_host_hit = 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_enables();
    t_ch3ctrl();
    t_errors();
    wrap_up();
  end
endmodule
`default_nettype wire
